// [design/rtcca_top.sv]
// rtcca_top: control, calibration, output and alarm repeat logic of the clock calendar
// assumes one AHB-Lite master, hresetn is the power-on reset, sys inputs are on hclk
//
// The placing of the registers and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
module rtcca_top #(
   parameter int RUN_TIMEOUT = rtcca_pkg::RUN_TIMEOUT_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic timekeep_clk_pin,
   input wire rtcca_pkg::rtcca_sys_t sys,
   output logic clock_calendar_enable,
   output logic bus_clock_enable,
   output logic clock_calendar_pin_out,
   output logic clock_calendar_pin_oe,
   output logic irq
);
   import rtcca_pkg::*;

   function automatic logic [9:0] trim_mag(input logic [9:0] c);
      trim_mag = c[9] ? 10'((~c) + 10'h001) : c;
   endfunction : trim_mag

   ////////////////////////////////////////////////////////////////////////
   // bus slave: zero wait, registered read data
   logic wr_pend;
   logic [7:0] wr_addr;
   logic next_wr_pend;
   logic [7:0] next_wr_addr;
   logic [31:0] next_hrdata;
   logic addr_ok;

   rtcca_ctrl_t ctrl, next_ctrl;
   rtcca_alrm_t alrm, next_alrm;
   logic [IRQ_W-1:0] irq_stat, next_irq_stat;
   logic [IRQ_W-1:0] irq_mask, next_irq_mask;

   logic clk_running;
   logic half_second_flag;
   logic rollover_sync_flag;
   logic alarm_sync_flag;
   logic alarm_pulse;
   logic seconds_clock;
   logic sec_tick;
   logic alarm_hit;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

   function automatic logic [31:0] read_mux(input logic [7:0] a);
      read_mux = 32'h0000_0000;
      unique case (a)
         ADDR_CTRL: begin
            read_mux[CAL_MSB:CAL_LSB] = ctrl.cal;
            read_mux[BIT_ON] = ctrl.on;
            read_mux[BIT_IDLE_STOP] = ctrl.idle_stop;
            read_mux[BIT_OUT_SEL] = ctrl.output_source_select;
            read_mux[BIT_CLK_RUN] = clk_running;
            read_mux[BIT_UNLOCK] = ctrl.write_unlock;
            read_mux[BIT_ROLL_SYNC] = rollover_sync_flag;
            read_mux[BIT_HALF_SEC] = half_second_flag;
            read_mux[BIT_OUT_EN] = ctrl.output_enable_bit;
         end
         ADDR_ALRM: begin
            read_mux[BIT_ARM] = alrm.alarm_arm;
            read_mux[BIT_WRAP] = alrm.repeat_wrap_enable;
            read_mux[BIT_ALRM_SYNC] = alarm_sync_flag;
            read_mux[7:0] = alrm.alarm_repeat_count;
         end
         ADDR_IRQ_STAT: read_mux[IRQ_W-1:0] = irq_stat;
         ADDR_IRQ_MASK: read_mux[IRQ_W-1:0] = irq_mask;
         default: read_mux = 32'h0000_0000;
      endcase
   endfunction : read_mux

   always_comb begin
      next_wr_pend = addr_ok && hwrite;
      next_wr_addr = addr_ok ? haddr[7:0] : wr_addr;
      // unmapped or unaligned addresses read zero and drop writes
      next_hrdata = (addr_ok && !hwrite && haddr[1:0] == 2'h0) ? read_mux(haddr[7:0]) : 32'h0000_0000;
      if (haddr[1:0] != 2'h0) begin
         next_wr_pend = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hrdata <= 32'h0000_0000;
      end else begin
         wr_pend <= next_wr_pend;
         wr_addr <= next_wr_addr;
         hrdata <= next_hrdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control, alarm and interrupt registers
   logic wr_ctrl, wr_alrm, wr_stat, wr_mask;
   assign wr_ctrl = wr_pend && wr_addr == ADDR_CTRL;
   assign wr_alrm = wr_pend && wr_addr == ADDR_ALRM;
   assign wr_stat = wr_pend && wr_addr == ADDR_IRQ_STAT;
   assign wr_mask = wr_pend && wr_addr == ADDR_IRQ_MASK;

   always_comb begin
      next_ctrl = ctrl;
      next_alrm = alrm;
      next_irq_stat = irq_stat;
      next_irq_mask = irq_mask;
      if (wr_ctrl) begin
         next_ctrl.cal = hwdata[CAL_MSB:CAL_LSB];
         next_ctrl.idle_stop = hwdata[BIT_IDLE_STOP];
         next_ctrl.output_source_select = hwdata[BIT_OUT_SEL];
         next_ctrl.output_enable_bit = hwdata[BIT_OUT_EN];
         // old unlock value guards the enable, so one write cannot unlock and flip it
         if (ctrl.write_unlock) begin
            next_ctrl.on = hwdata[BIT_ON];
         end
         // clearing unlock is always allowed
         next_ctrl.write_unlock = hwdata[BIT_UNLOCK] && (ctrl.write_unlock || sys.unlock_seq_done);
      end
      if (wr_alrm) begin
         next_alrm.alarm_arm = hwdata[BIT_ARM];
         next_alrm.repeat_wrap_enable = hwdata[BIT_WRAP];
         next_alrm.alarm_repeat_count = hwdata[7:0];
      end
      // hardware update wins over a same-cycle software write
      if (alarm_hit) begin
         if (alrm.alarm_repeat_count == 8'h00 && !alrm.repeat_wrap_enable) begin
            next_alrm.alarm_arm = 1'b0;
            next_alrm.alarm_repeat_count = alrm.alarm_repeat_count;
         end else begin
            next_alrm.alarm_repeat_count = 8'(alrm.alarm_repeat_count - 8'h01);
         end
      end
      if (wr_mask) begin
         next_irq_mask = hwdata[IRQ_W-1:0];
      end
      if (wr_stat) begin
         next_irq_stat = irq_stat & ~hwdata[IRQ_W-1:0];
      end
      if (sys.other_reset) begin
         next_irq_stat = '0;
         next_irq_mask = '0;
      end
      // set wins over clear
      next_irq_stat[IRQ_ALARM] = next_irq_stat[IRQ_ALARM] | alarm_hit;
      next_irq_stat[IRQ_SECOND] = next_irq_stat[IRQ_SECOND] | sec_tick;
   end

   // other reset sources never touch ctrl or alrm
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= rtcca_ctrl_t'({CTRL_RESET[CAL_MSB:CAL_LSB], 5'h00});
         alrm <= rtcca_alrm_t'(ALRM_RESET[9:0]);
         irq_stat <= '0;
         irq_mask <= '0;
      end else begin
         ctrl <= next_ctrl;
         alrm <= next_alrm;
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
      end
   end

   assign irq = |(irq_stat & irq_mask);
   assign clock_calendar_enable = ctrl.on;
   assign bus_clock_enable = !(ctrl.idle_stop && sys.cpu_idle);

   ////////////////////////////////////////////////////////////////////////
   // timekeeping clock: synchronise, detect edges, watch for activity
   logic tk_meta, tk_sync, tk_prev;
   logic tk_edge;
   logic [15:0] idle_cnt, next_idle_cnt;
   logic next_clk_running;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tk_meta <= 1'b0;
         tk_sync <= 1'b0;
         tk_prev <= 1'b0;
      end else begin
         tk_meta <= timekeep_clk_pin;
         tk_sync <= tk_meta;
         tk_prev <= tk_sync;
      end
   end

   assign tk_edge = tk_sync && !tk_prev;

   always_comb begin
      next_idle_cnt = idle_cnt;
      next_clk_running = clk_running;
      if (tk_edge) begin
         next_idle_cnt = 16'h0000;
         next_clk_running = ctrl.on;
      end else if (idle_cnt >= 16'(RUN_TIMEOUT - 1)) begin
         next_clk_running = 1'b0;
      end else begin
         next_idle_cnt = 16'(idle_cnt + 16'h0001);
      end
      if (!ctrl.on) begin
         next_clk_running = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         idle_cnt <= 16'h0000;
         clk_running <= 1'b0;
      end else begin
         idle_cnt <= next_idle_cnt;
         clk_running <= next_clk_running;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // second prescaler with per-minute drift trim
   logic [PRE_W-1:0] pre, next_pre;
   logic [5:0] sec, next_sec;
   logic [9:0] trim_left, next_trim_left;
   logic trim_add, next_trim_add;
   logic tick;
   logic minute_edge;

   // inserted pulses use idle hclk cycles; suppressed ones swallow real edges
   assign tick = ctrl.on && ((tk_edge && !(!trim_add && trim_left != 10'h000)) ||
                             (!tk_edge && trim_add && trim_left != 10'h000));
   assign sec_tick = tick && pre == TICKS_LAST;
   assign minute_edge = sec_tick && sec == SEC_LAST;

   always_comb begin
      next_pre = pre;
      next_sec = sec;
      next_trim_left = trim_left;
      next_trim_add = trim_add;
      if (ctrl.on && trim_left != 10'h000 && (tk_edge != trim_add)) begin
         next_trim_left = 10'(trim_left - 10'h001);
      end
      if (tick) begin
         next_pre = PRE_W'(pre + 1'b1);
         if (sec_tick) begin
            next_sec = (sec == SEC_LAST) ? 6'h00 : 6'(sec + 6'h01);
         end
      end
      if (minute_edge) begin
         next_trim_left = trim_mag(ctrl.cal);
         next_trim_add = !ctrl.cal[9];
      end
      if (sys.time_sec_write) begin
         next_pre = '0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre <= '0;
         sec <= 6'h00;
         trim_left <= 10'h000;
         trim_add <= 1'b0;
      end else begin
         pre <= next_pre;
         sec <= next_sec;
         trim_left <= next_trim_left;
         trim_add <= next_trim_add;
      end
   end

   assign half_second_flag = pre >= TICKS_HALF;
   assign seconds_clock = pre >= TICKS_HALF;
   assign rollover_sync_flag = ctrl.on && pre >= SYNC_START;
   assign alarm_sync_flag = alrm.alarm_arm && rollover_sync_flag;
   assign alarm_hit = ctrl.on && alrm.alarm_arm && sys.alarm_event;

   ////////////////////////////////////////////////////////////////////////
   // output pin
   logic next_alarm_pulse, next_pin_out, next_pin_oe;

   always_comb begin
      next_alarm_pulse = alarm_hit;
      next_pin_oe = ctrl.output_enable_bit;
      next_pin_out = 1'b0;
      if (ctrl.output_enable_bit) begin
         next_pin_out = ctrl.output_source_select ? seconds_clock : alarm_pulse;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         alarm_pulse <= 1'b0;
         clock_calendar_pin_out <= 1'b0;
         clock_calendar_pin_oe <= 1'b0;
      end else begin
         alarm_pulse <= next_alarm_pulse;
         clock_calendar_pin_out <= next_pin_out;
         clock_calendar_pin_oe <= next_pin_oe;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   property p_on_locked;
      @(posedge hclk) disable iff (!hresetn)
      (wr_ctrl && !ctrl.write_unlock) |=> $stable(ctrl.on);
   endproperty
   a_on_locked: assert property (p_on_locked) else $error("enable changed while locked");

   property p_unlock_seq;
      @(posedge hclk) disable iff (!hresetn)
      ($rose(ctrl.write_unlock)) |-> $past(sys.unlock_seq_done);
   endproperty
   a_unlock_seq: assert property (p_unlock_seq) else $error("unlock set without sequence");

   property p_bus_gate;
      @(posedge hclk) disable iff (!hresetn)
      bus_clock_enable == !(ctrl.idle_stop && sys.cpu_idle);
   endproperty
   a_bus_gate: assert property (p_bus_gate) else $error("bus clock gate wrong");

   property p_pin_off;
      @(posedge hclk) disable iff (!hresetn)
      !ctrl.output_enable_bit |=> !clock_calendar_pin_out && !clock_calendar_pin_oe;
   endproperty
   a_pin_off: assert property (p_pin_off) else $error("pin active while disabled");

   property p_pin_alarm;
      @(posedge hclk) disable iff (!hresetn)
      (alarm_hit && ctrl.output_enable_bit && !ctrl.output_source_select) ##1
      (ctrl.output_enable_bit && !ctrl.output_source_select) |=> clock_calendar_pin_out;
   endproperty
   a_pin_alarm: assert property (p_pin_alarm) else $error("alarm pulse missing on pin");

   property p_half_clear;
      @(posedge hclk) disable iff (!hresetn)
      sys.time_sec_write |=> !half_second_flag;
   endproperty
   a_half_clear: assert property (p_half_clear) else $error("half second not cleared");

   property p_count_dec;
      @(posedge hclk) disable iff (!hresetn)
      (alarm_hit && (alrm.alarm_repeat_count != 8'h00 || alrm.repeat_wrap_enable))
      |=> alrm.alarm_repeat_count == 8'($past(alrm.alarm_repeat_count) - 8'h01);
   endproperty
   a_count_dec: assert property (p_count_dec) else $error("repeat count not decremented");

   property p_disarm;
      @(posedge hclk) disable iff (!hresetn)
      (alarm_hit && alrm.alarm_repeat_count == 8'h00 && !alrm.repeat_wrap_enable)
      |=> !alrm.alarm_arm && alrm.alarm_repeat_count == 8'h00;
   endproperty
   a_disarm: assert property (p_disarm) else $error("alarm not disarmed");

   property p_off_still;
      @(posedge hclk) disable iff (!hresetn)
      !ctrl.on |-> !tick ##1 !clk_running;
   endproperty
   a_off_still: assert property (p_off_still) else $error("timekeeping runs while off");

   property p_trim_load;
      @(posedge hclk) disable iff (!hresetn)
      minute_edge && !sys.time_sec_write |=> trim_left == trim_mag($past(ctrl.cal)) && trim_add == !$past(ctrl.cal[9]);
   endproperty
   a_trim_load: assert property (p_trim_load) else $error("trim not loaded at minute");

endmodule : rtcca_top

// [common/rtcca_pkg.sv]
// rtcca_pkg: constants, field layout and carrier types of the clock control block
// assumes a 32-bit AHB-Lite register bus on hclk and a slow timekeeping clock pin
// Behaviour
// - drift trim is signed ten bits; positive N adds N pulses per minute, max 511
// - negative trim removes 1 (all ones) up to 512 pulses per minute; zero none
// - clock calendar runs while enable bit 15 is one, disabled otherwise
// - writes to the enable bit take effect only while write unlock is set
// - write unlock can be set only after the system write sequence is done
// - idle stop bit 13 gates the bus clock off while the processor idles
// - output select bit 7 picks seconds clock when one, alarm pulse when zero
// - output pin stays inactive unless output enable bit 0 is one
// - read-only bit 6 shows the timekeeping clock is actively running
// - read-only half second flag clears whenever software writes the seconds field
// - control and alarm control registers reset only on power-on reset
// - eight-bit repeat count: zero gives one trigger, all ones gives 256
// - repeat count decrements on each alarm event; wraps 00 to ff only with wrap enable
// - alarm arm clears itself on an event at count 00 with wrap enable zero
package rtcca_pkg;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_ALRM = 8'h10;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h24;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] ALRM_RESET = 32'h0000_0000;
   localparam int CAL_LSB = 16;
   localparam int CAL_MSB = 25;
   localparam int BIT_ON = 15;
   localparam int BIT_IDLE_STOP = 13;
   localparam int BIT_OUT_SEL = 7;
   localparam int BIT_CLK_RUN = 6;
   localparam int BIT_UNLOCK = 3;
   localparam int BIT_ROLL_SYNC = 2;
   localparam int BIT_HALF_SEC = 1;
   localparam int BIT_OUT_EN = 0;
   localparam int BIT_ARM = 15;
   localparam int BIT_WRAP = 14;
   localparam int BIT_ALRM_SYNC = 12;
   localparam int IRQ_ALARM = 0;
   localparam int IRQ_SECOND = 1;
   localparam int IRQ_W = 2;
   localparam int PRE_W = 15;
   localparam logic [PRE_W-1:0] TICKS_LAST = 15'h7fff;
   localparam logic [PRE_W-1:0] TICKS_HALF = 15'h4000;
   localparam logic [PRE_W-1:0] SYNC_START = 15'h7fe0;
   localparam logic [5:0] SEC_LAST = 6'h3b;
   localparam int CLK_NS = 5;
   localparam int RUN_TIMEOUT_NS = 100000;
   localparam int RUN_TIMEOUT_CYC = RUN_TIMEOUT_NS / CLK_NS;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;

   typedef struct packed {
      logic [9:0] cal;
      logic on;
      logic idle_stop;
      logic output_source_select;
      logic write_unlock;
      logic output_enable_bit;
   } rtcca_ctrl_t;

   typedef struct packed {
      logic alarm_arm;
      logic repeat_wrap_enable;
      logic [7:0] alarm_repeat_count;
   } rtcca_alrm_t;

   typedef struct packed {
      logic cpu_idle;
      logic unlock_seq_done;
      logic time_sec_write;
      logic alarm_event;
      logic other_reset;
   } rtcca_sys_t;
endpackage : rtcca_pkg

// [verif/rtc_control_calibration_alarm_repeat_test.sv]
// rtc_control_calibration_alarm_repeat_test: self-checking bench for the clock control block
// assumes rtcca_top with zero-wait AHB-Lite slave; bench is the only bus master
`timescale 1ns/1ps
module rtc_control_calibration_alarm_repeat_test;
   import rtcca_pkg::*;
   ////////////////////////////////////////////////////////////////////////////////
   localparam logic [31:0] M_ON = 32'h1 << BIT_ON;
   localparam logic [31:0] M_IDLE = 32'h1 << BIT_IDLE_STOP;
   localparam logic [31:0] M_SEL = 32'h1 << BIT_OUT_SEL;
   localparam logic [31:0] M_RUN = 32'h1 << BIT_CLK_RUN;
   localparam logic [31:0] M_UNL = 32'h1 << BIT_UNLOCK;
   localparam logic [31:0] M_OE = 32'h1 << BIT_OUT_EN;
   localparam logic [31:0] A_ARM = 32'h1 << BIT_ARM;
   localparam logic [31:0] A_WRAP = 32'h1 << BIT_WRAP;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic timekeep_clk_pin = 1'b0;
   logic pin_run = 1'b0;
   logic [2:0] pin_div = 3'h0;
   rtcca_sys_t sys = '0;
   logic clock_calendar_enable;
   logic bus_clock_enable;
   logic clock_calendar_pin_out;
   logic clock_calendar_pin_oe;
   logic irq;
   int failures = 0;
   int check_count = 0;
   logic [9:0] cal_tab [5] = '{10'h1ff, 10'h001, 10'h000, 10'h3ff, 10'h200};

   // run-timeout kept short so the stop of the pin is seen quickly; pin period is 16 cycles
   rtcca_top #(.RUN_TIMEOUT(64)) u_rtcca_top (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .timekeep_clk_pin(timekeep_clk_pin), .sys(sys),
      .clock_calendar_enable(clock_calendar_enable), .bus_clock_enable(bus_clock_enable),
      .clock_calendar_pin_out(clock_calendar_pin_out), .clock_calendar_pin_oe(clock_calendar_pin_oe), .irq(irq)
   );

   always #2.5 hclk = ~hclk;

   always @(posedge hclk) begin
      if (pin_run) begin
         pin_div <= pin_div + 3'h1;
         if (pin_div == 3'h7) begin
            timekeep_clk_pin <= ~timekeep_clk_pin;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic conclude();
      if (failures == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : conclude

   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 64);
      if (hreadyout !== 1'b1) begin
         failures++;
         conclude();
      end
   endtask : wait_ready

   task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= 1'b1;
      wait_ready();
      htrans <= 2'h0;
      hwrite <= 1'b0;
      hwdata <= d;
      wait_ready();
   endtask : bus_write

   task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= {24'h0, a};
      hwrite <= 1'b0;
      wait_ready();
      htrans <= 2'h0;
      wait_ready();
      d = hrdata;
   endtask : bus_read

   task automatic check_reg(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] got;
      bus_read(a, got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_reg

   task automatic check_pin(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_pin

   // one alarm event pulse, then watch the pin long enough for its delayed pulse
   task automatic alarm_watch(input logic exp_high);
      logic seen;
      seen = 1'b0;
      sys.alarm_event <= 1'b1;
      @(posedge hclk);
      sys.alarm_event <= 1'b0;
      repeat (6) begin
         @(posedge hclk);
         seen = seen | clock_calendar_pin_out;
      end
      check_pin(seen, exp_high);
   endtask : alarm_watch
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (50000) @(posedge hclk);
      failures++;
      conclude();
   end

   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check_reg(ADDR_CTRL, CTRL_RESET);
      check_reg(ADDR_ALRM, ALRM_RESET);
      check_pin(bus_clock_enable, 1'b1);
      // unlock attempt without the system sequence must be dropped
      bus_write(ADDR_CTRL, M_ON | M_UNL);
      check_reg(ADDR_CTRL, 32'h0);
      check_pin(clock_calendar_enable, 1'b0);
      sys.unlock_seq_done <= 1'b1;
      bus_write(ADDR_CTRL, M_UNL);
      sys.unlock_seq_done <= 1'b0;
      check_reg(ADDR_CTRL, M_UNL);
      bus_write(ADDR_CTRL, M_ON);
      check_reg(ADDR_CTRL, M_ON);
      bus_write(ADDR_CTRL, 32'h0);
      check_reg(ADDR_CTRL, M_ON);
      check_pin(clock_calendar_enable, 1'b1);
      sys.unlock_seq_done <= 1'b1;
      bus_write(ADDR_CTRL, M_ON | M_UNL);
      foreach (cal_tab[i]) begin
         bus_write(ADDR_CTRL, {6'h0, cal_tab[i], 16'h0} | M_ON | M_UNL);
         check_reg(ADDR_CTRL, {6'h0, cal_tab[i], 16'h0} | M_ON | M_UNL);
      end
      bus_write(ADDR_CTRL, M_ON | M_UNL | M_IDLE);
      sys.cpu_idle <= 1'b1;
      @(posedge hclk);
      check_pin(bus_clock_enable, 1'b0);
      bus_write(ADDR_CTRL, M_ON | M_UNL);
      @(posedge hclk);
      check_pin(bus_clock_enable, 1'b1);
      sys.cpu_idle <= 1'b0;
      // sync flag cannot be high here: prescaler is far from its rollover window
      bus_write(ADDR_ALRM, A_ARM | 32'h3);
      alarm_watch(1'b0);
      check_pin(clock_calendar_pin_oe, 1'b0);
      bus_write(ADDR_CTRL, M_ON | M_UNL | M_OE | M_SEL);
      alarm_watch(1'b0);
      check_pin(clock_calendar_pin_oe, 1'b1);
      bus_write(ADDR_CTRL, M_ON | M_UNL | M_OE);
      alarm_watch(1'b1);
      check_reg(ADDR_ALRM, A_ARM);
      check_pin(irq, 1'b0);
      alarm_watch(1'b1);
      check_reg(ADDR_ALRM, 32'h0);
      alarm_watch(1'b0);
      bus_write(ADDR_ALRM, A_ARM | A_WRAP);
      alarm_watch(1'b1);
      check_reg(ADDR_ALRM, A_ARM | A_WRAP | 32'hff);
      check_reg(ADDR_IRQ_STAT, 32'h1);
      bus_write(ADDR_IRQ_MASK, 32'h1);
      @(posedge hclk);
      check_pin(irq, 1'b1);
      bus_write(ADDR_IRQ_STAT, 32'h1);
      @(posedge hclk);
      check_pin(irq, 1'b0);
      check_reg(ADDR_IRQ_STAT, 32'h0);
      sys.other_reset <= 1'b1;
      @(posedge hclk);
      sys.other_reset <= 1'b0;
      @(posedge hclk);
      check_reg(ADDR_CTRL, M_ON | M_UNL | M_OE);
      check_reg(ADDR_ALRM, A_ARM | A_WRAP | 32'hff);
      check_reg(ADDR_IRQ_MASK, 32'h0);
      bus_write(8'h30, 32'hffff_ffff);
      check_reg(8'h30, 32'h0);
      check_reg(ADDR_CTRL, M_ON | M_UNL | M_OE);
      pin_run <= 1'b1;
      repeat (100) @(posedge hclk);
      // seconds write zeroes the prescaler, half second flag must read zero
      sys.time_sec_write <= 1'b1;
      @(posedge hclk);
      sys.time_sec_write <= 1'b0;
      repeat (100) @(posedge hclk);
      check_reg(ADDR_CTRL, M_ON | M_UNL | M_OE | M_RUN);
      pin_run <= 1'b0;
      repeat (200) @(posedge hclk);
      check_reg(ADDR_CTRL, M_ON | M_UNL | M_OE);
      bus_write(ADDR_CTRL, M_UNL);
      // bus left quiet for a cycle after clearing the enable
      @(posedge hclk);
      check_pin(clock_calendar_enable, 1'b0);
      conclude();
   end
endmodule : rtc_control_calibration_alarm_repeat_test
